// ### common/epbp_pkg.sv
/*
  constants, formats and state codes of the external parallel bus port.
  assumes a single 100 MHz clock and an asynchronous active-low reset.
*/
package epbp_pkg;
  localparam logic [31:0] EXT_BASE = 32'h0040_0000;
  localparam logic [4:0] BANK_SHIFT_BASE = 5'h0d;
  localparam logic [4:0] PAGE_SHIFT_BASE = 5'h08;
  localparam logic [2:0] BANK_COUNT = 3'h4;
  localparam logic [3:0] SELECTS_IDLE = 4'hf;
  localparam int SYNC_WIDTH = 5;
  localparam logic [4:0] SYNC_RESET = 5'h1f;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int ACK_SETTLE_NS = 30;
  localparam logic [1:0] ACK_SETTLE_CYCLES =
    2'((ACK_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  typedef enum logic [1:0] {
    FMT_WORD32 = 2'h0,
    FMT_EXT40 = 2'h1,
    FMT_SHORT16 = 2'h2,
    FMT_BOOT8 = 2'h3
  } epbp_format_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACCESS = 3'h2,
    ST_RELEASE = 3'h4
  } epbp_state_type;
endpackage

// ### dv/epbp_mem_model.sv
/*
  far-side memory of the bus port: answers reads, keeps the last write, stalls on request.
  assumes the bench resolves the shared pins and feeds their levels here.
*/
`timescale 1ns/1ns
module epbp_mem_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] a_i,
  input wire logic [47:0] d_i,
  input wire logic [3:0] sel_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic pg_i,
  input wire logic [7:0] wait_i,
  output logic [47:0] d_o,
  output logic d_oe_o,
  output logic ack_o,
  output logic [47:0] cap_o,
  output logic [3:0] sel_o,
  output logic pg_o,
  output logic [3:0] last_o,
  output logic [7:0] cnt_o
);
  logic act_q;
  logic [7:0] left;
  wire picked = sel_n_i != 4'hf;
  wire act = picked & ~(rd_n_i & wr_n_i);
  // ack low from the strobe's first cycle while wait_i is nonzero and waits remain, pulled high otherwise
  assign ack_o = ~(act & (act_q ? left != 8'h0 : wait_i != 8'h0));
  assign d_oe_o = act & ~rd_n_i;
  assign d_o = {a_i[15:0], ~a_i};
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_q <= 1'h0;
      left <= 8'h0;
      cnt_o <= 8'h0;
      sel_o <= 4'hf;
      pg_o <= 1'h0;
      cap_o <= 48'h0;
      last_o <= 4'hf;
    end else begin
      act_q <= act;
      if (act & ~act_q) begin
        left <= wait_i - {7'h0, wait_i != 8'h0};
        cnt_o <= cnt_o + 8'h1;
        sel_o <= sel_n_i;
        pg_o <= pg_i;
      end else if (left != 8'h0) begin
        left <= left - 8'h1;
      end
      if (act & ~wr_n_i) cap_o <= d_i;
      if (picked) last_o <= sel_n_i;
    end
  end
endmodule // epbp_mem_model

// ### dv/external_parallel_bus_port_tb.sv
/*
  self-checking bench of the bus port: core accesses, slave accesses, suspend.
  assumes epbp_mem_model answers on the far side of the pins.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module external_parallel_bus_port_tb;
  localparam logic [31:0] B = epbp_pkg::EXT_BASE;
  typedef struct {logic [1:0] k; logic w; logic [47:0] v, m; logic [3:0] s; logic pc, p;
    logic [31:0] a;} epbp_note_type;
  epbp_note_type q[$];
  epbp_note_type mn;
  int mismatches = 0, n_tests = 0;
  logic clk = 1'h0, rst_n = 1'h0, mst = 1'h1, vld = 1'h0, rw = 1'h0, cnd = 1'h1, sb_n = 1'h1;
  logic b_doe = 1'h0, b_rd_n = 1'h1, b_wr_n = 1'h1, b_es_n = 1'h1, es_last = 1'h1;
  logic [3:0] bsz = 4'h0;
  logic [1:0] fmt = 2'h0;
  logic [31:0] ad = 32'h0, b_ad = 32'h0, seed = 32'h142f;
  logic [39:0] wd = 40'h12_3456_789a;
  logic [47:0] srd = 48'h5a5a_c3c3_0ff0, b_d = 48'h0, d_last = 48'h0;
  logic [7:0] wt = 8'h0;
  logic rdy, rv, sv, swr, a_oe, d_oe, s_oe, rd_o, rd_oe, wr_o, wr_oe, es_o, es_oe, pg, pg_oe;
  logic rc, rc_oe, m_oe, ack, m_pg;
  logic [39:0] rdat;
  logic [31:0] sa, a_o;
  logic [47:0] sd, d_o, m_d, cap;
  logic [3:0] sel_n, m_sel, m_last;
  logic [7:0] m_cnt;
  wire [31:0] a_w = a_oe ? a_o : b_ad;
  wire [47:0] d_w = d_oe ? d_o : m_oe ? m_d : b_doe ? b_d : ~d_last;
  wire [3:0] sel_nw = s_oe ? sel_n : 4'hf;
  wire rd_nw = rd_oe ? rd_o : b_rd_n;
  wire wr_nw = wr_oe ? wr_o : b_wr_n;
  wire es_nw = es_oe ? es_o : b_es_n;
  wire pg_w = pg_oe & pg;
  epbp_port epbp_port_inst (.clk_i(clk), .reset_n_i(rst_n), .is_master_i(mst),
    .bank_size_i(bsz), .page_size_i(3'h0), .req_valid_i(vld), .req_write_i(rw),
    .req_cond_true_i(cnd), .req_format_i(fmt), .req_addr_i(ad), .req_wdata_i(wd),
    .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat), .slv_valid_o(sv),
    .slv_write_o(swr), .slv_addr_o(sa), .slv_wdata_o(sd), .slv_rdata_i(srd),
    .ext_address_i(a_w), .ext_address_o(a_o), .ext_address_oe_o(a_oe), .ext_data_bus_i(d_w),
    .ext_data_bus_o(d_o), .ext_data_bus_oe_o(d_oe), .bank_select_n_o(sel_n),
    .bank_select_oe_o(s_oe), .rd_strobe_n_i(rd_nw), .rd_strobe_n_o(rd_o),
    .rd_strobe_oe_o(rd_oe), .wr_strobe_n_i(wr_nw), .wr_strobe_n_o(wr_o),
    .wr_strobe_oe_o(wr_oe), .early_store_select_n_i(es_nw), .early_store_select_n_o(es_o),
    .early_store_select_oe_o(es_oe), .page_boundary_o(pg), .page_boundary_oe_o(pg_oe),
    .bus_reference_clock_o(rc), .bus_reference_clock_oe_o(rc_oe),
    .suspend_tristate_request_n_i(sb_n), .ack_i(ack));
  epbp_mem_model epbp_mem_model_inst (.clk_i(clk), .reset_n_i(rst_n), .a_i(a_w), .d_i(d_w),
    .sel_n_i(sel_nw), .rd_n_i(rd_nw), .wr_n_i(wr_nw), .pg_i(pg_w), .wait_i(wt), .d_o(m_d),
    .d_oe_o(m_oe), .ack_o(ack), .cap_o(cap), .sel_o(m_sel), .pg_o(m_pg), .last_o(m_last),
    .cnt_o(m_cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) d_last <= d_w;
  always @(posedge clk) if (sel_nw != 4'hf) es_last <= es_nw;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [47:0] lmask(input logic [1:0] f);
    case (f)
      2'h0: return 48'hffff_ffff_0000;
      2'h1: return 48'hffff_ffff_ff00;
      2'h2: return 48'h0000_ffff_0000;
      default: return 48'h0000_00ff_0000;
    endcase
  endfunction
  task automatic end_sim();
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic w, c, input logic [1:0] f, input logic [31:0] a,
      input logic [3:0] s, input logic pc, p, output int lat);
    logic [47:0] m, d, v;
    m = lmask(f);
    d = {a[15:0], ~a} & m;
    v = w ? ((f == 2'h1) ? {wd, 8'h0} : {wd[31:0], 16'h0}) & m : (f == 2'h1) ? d >> 8 : d >> 16;
    q.push_back('{c ? 2'h0 : 2'h2, w, v, m, s, pc, p, a});
    {rw, cnd, fmt, ad, vld} = {w, c, f, a, 1'h1};
    for (int i = 0; i < 50 && rdy !== 1'h1; i++) @(posedge clk) #1;
    @(posedge clk);
    #1;
    vld = 1'h0;
    lat = 0;
    while (rv !== 1'h1 && lat < 400) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask
  task automatic slv(input logic w, input logic [31:0] a, input logic [47:0] d);
    q.push_back('{2'h1, w, d, 48'h0, 4'h0, 1'h0, 1'h0, a});
    {b_ad, b_d, b_doe, b_es_n} = {a, d, w, ~w};
    {b_wr_n, b_rd_n} = {~w, w};
    repeat (8) @(posedge clk);
    #1;
    if (!w) `CHK({d_oe, d_o}, {1'h1, srd})
    {b_wr_n, b_rd_n, b_es_n, b_doe} = 4'he;
    repeat (4) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    #2;
    if (rv === 1'h1 || sv === 1'h1) begin
      `CHK(q.size() != 0, 1'h1)
      if (q.size() != 0) begin
        mn = q.pop_front();
        if (mn.k == 2'h1) begin
          `CHK({swr, sa}, {mn.w, mn.a})
          if (mn.w) `CHK(sd, mn.v)
        end else if (mn.k == 2'h0) begin
          `CHK(m_sel, mn.s)
          if (mn.pc) `CHK(m_pg, mn.p)
          if (mn.w) `CHK(cap & mn.m, mn.v)
          else `CHK(rdat, mn.v[39:0])
        end
      end
    end
  end
  initial begin
    int lat, sh;
    logic [31:0] off;
    logic [7:0] c0;
    logic r0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'h1;
    acc(1'h0, 1'h1, 2'h0, B + 32'h10, 4'he, 1'h0, 1'h0, lat);
    acc(1'h1, 1'h1, 2'h0, B + 32'h11, 4'he, 1'h1, 1'h0, lat);
    acc(1'h0, 1'h1, 2'h1, B + 32'h110, 4'he, 1'h1, 1'h1, lat);
    acc(1'h0, 1'h1, 2'h2, B + 32'h2310, 4'hd, 1'h1, 1'h0, lat);
    c0 = m_cnt;
    acc(1'h1, 1'h0, 2'h0, B + 32'h4000, 4'hb, 1'h0, 1'h0, lat);
    `CHK(lat, 1)
    `CHK({m_cnt, m_last, es_last}, {c0, 4'hb, 1'h0})
    acc(1'h0, 1'h0, 2'h0, B + 32'h6000, 4'h7, 1'h0, 1'h0, lat);
    `CHK({m_last, es_last}, {4'h7, 1'h1})
    wt = 8'h8;
    acc(1'h0, 1'h1, 2'h3, B + 32'h20, 4'he, 1'h0, 1'h0, lat);
    `CHK(lat > 9, 1'h1)
    wt = 8'h14;
    fork
      acc(1'h0, 1'h1, 2'h0, B + 32'h30, 4'he, 1'h0, 1'h0, lat);
      begin
        repeat (3) @(posedge clk);
        #1;
        sb_n = 1'h0;
        repeat (6) @(posedge clk);
        #1;
        `CHK({a_oe, d_oe, s_oe, rd_oe, wr_oe, rdy}, 6'h0)
        repeat (8) @(posedge clk);
        #1;
        sb_n = 1'h1;
      end
    join
    wt = 8'h0;
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      bsz = {2'h0, seed[1:0]};
      sh = 13 + seed[1:0];
      off = seed & ((32'h4 << sh) - 32'h1);
      wd = {seed[7:0], xs(seed)};
      acc(seed[31], 1'h1, 2'(i), B + off, ~(4'h1 << (off >> sh)), 1'h0, 1'h0, lat);
    end
    r0 = rc;
    @(posedge clk);
    #1;
    `CHK({rc_oe, rc}, {1'h1, ~r0})
    mst = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({a_oe, s_oe, pg_oe, rc_oe, wr_oe, es_oe}, 6'h0)
    slv(1'h1, seed, {seed[15:0], ~seed});
    slv(1'h0, ~seed, 48'h0);
    mst = 1'h1;
    repeat (4) @(posedge clk);
    `CHK(q.size(), 0)
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule // external_parallel_bus_port_tb

// ### rtl/epbp_port.sv
/*
  external parallel bus port: master accesses, slave decoding, tristate control.
  assumes config inputs are static during an access and the core holds a
  request until req_ready_o.
*/
`timescale 1ns/1ns
module epbp_port (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic is_master_i,
  input wire logic [3:0] bank_size_i,
  input wire logic [2:0] page_size_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_cond_true_i,
  input wire logic [1:0] req_format_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [39:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [39:0] rsp_rdata_o,
  output logic slv_valid_o,
  output logic slv_write_o,
  output logic [31:0] slv_addr_o,
  output logic [47:0] slv_wdata_o,
  input wire logic [47:0] slv_rdata_i,
  input wire logic [31:0] ext_address_i,
  output logic [31:0] ext_address_o,
  output logic ext_address_oe_o,
  input wire logic [47:0] ext_data_bus_i,
  output logic [47:0] ext_data_bus_o,
  output logic ext_data_bus_oe_o,
  output logic [3:0] bank_select_n_o,
  output logic bank_select_oe_o,
  input wire logic rd_strobe_n_i,
  output logic rd_strobe_n_o,
  output logic rd_strobe_oe_o,
  input wire logic wr_strobe_n_i,
  output logic wr_strobe_n_o,
  output logic wr_strobe_oe_o,
  input wire logic early_store_select_n_i,
  output logic early_store_select_n_o,
  output logic early_store_select_oe_o,
  output logic page_boundary_o,
  output logic page_boundary_oe_o,
  output logic bus_reference_clock_o,
  output logic bus_reference_clock_oe_o,
  input wire logic suspend_tristate_request_n_i,
  input wire logic ack_i
);
  epbp_pkg::epbp_state_type state;
  epbp_pkg::epbp_state_type next_state;
  logic [4:0] pins_s;
  logic [1:0] settle;
  logic settled_q;
  logic cur_write;
  logic cur_cond;
  logic [1:0] cur_format;
  logic [31:0] last_page;
  logic last_page_valid;
  logic slv_rd_prev;
  logic slv_wr_prev;
  logic [47:0] slv_data_q;

  // bank index from address and bank-size setting; bit 2 flags a hit
  function automatic logic [2:0] bank_of(input logic [31:0] a, input logic [3:0] sz);
    logic [31:0] idx;
    idx = (a - epbp_pkg::EXT_BASE) >> ({1'b0, sz} + epbp_pkg::BANK_SHIFT_BASE);
    bank_of = {1'b0, idx[1:0]};
    if (a >= epbp_pkg::EXT_BASE && idx < 32'(epbp_pkg::BANK_COUNT)) begin
      bank_of = {1'b1, idx[1:0]};
    end
  endfunction

  // data lane placement per format
  function automatic logic [47:0] place(input logic [1:0] f, input logic [39:0] d);
    place = 48'h0;
    unique case (f)
      epbp_pkg::FMT_WORD32: place[47:16] = d[31:0];
      epbp_pkg::FMT_EXT40: place[47:8] = d;
      epbp_pkg::FMT_SHORT16: place[31:16] = d[15:0];
      epbp_pkg::FMT_BOOT8: place[23:16] = d[7:0];
    endcase
  endfunction

  function automatic logic [39:0] extract(input logic [1:0] f, input logic [47:0] b);
    extract = 40'h0;
    unique case (f)
      epbp_pkg::FMT_WORD32: extract[31:0] = b[47:16];
      epbp_pkg::FMT_EXT40: extract = b[47:8];
      epbp_pkg::FMT_SHORT16: extract[15:0] = b[31:16];
      epbp_pkg::FMT_BOOT8: extract[7:0] = b[23:16];
    endcase
  endfunction

  epbp_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({suspend_tristate_request_n_i, ack_i, rd_strobe_n_i, wr_strobe_n_i,
      early_store_select_n_i}),
    .stable_o(pins_s)
  );

  wire suspend = ~pins_s[4];
  wire ack_s = pins_s[3];
  wire rd_s = pins_s[2];
  wire wr_s = pins_s[1];
  wire store_s = pins_s[0];

  wire req_fire = req_ready_o & req_valid_i;
  wire [2:0] req_bank = bank_of(req_addr_i, bank_size_i);
  wire [4:0] page_shift = {2'h0, page_size_i} + epbp_pkg::PAGE_SHIFT_BASE;
  wire [31:0] req_page = req_addr_i >> page_shift;
  wire req_bank0 = req_bank[2] & (req_bank[1:0] == 2'h0);
  wire req_new_page = req_bank0 & (~last_page_valid | (last_page != req_page));
  wire [3:0] req_selects = req_bank[2] ? ~(4'h1 << req_bank[1:0]) : epbp_pkg::SELECTS_IDLE;
  wire settled = (settle == epbp_pkg::ACK_SETTLE_CYCLES);
  wire access_done = (state == epbp_pkg::ST_ACCESS) & ~suspend &
    (~cur_cond | (settled_q & ack_s));
  wire master_drive = is_master_i & ~suspend;
  wire slv_rd_fall = ~is_master_i & slv_rd_prev & ~rd_s;
  wire slv_wr_fall = ~is_master_i & slv_wr_prev & ~wr_s;

  assign req_ready_o = (state == epbp_pkg::ST_IDLE) & master_drive;
  assign ext_address_oe_o = master_drive;
  assign bank_select_oe_o = master_drive;
  assign rd_strobe_oe_o = master_drive;
  assign wr_strobe_oe_o = master_drive;
  assign early_store_select_oe_o = master_drive;
  assign page_boundary_oe_o = master_drive;
  assign bus_reference_clock_oe_o = master_drive;
  assign ext_data_bus_oe_o = is_master_i ? (master_drive & cur_write & cur_cond &
    (state == epbp_pkg::ST_ACCESS)) : (~suspend & ~rd_s);

  always_comb begin
    next_state = state;
    unique case (state)
      epbp_pkg::ST_IDLE: if (req_fire) next_state = epbp_pkg::ST_ACCESS;
      epbp_pkg::ST_ACCESS: if (access_done) next_state = epbp_pkg::ST_RELEASE;
      epbp_pkg::ST_RELEASE: next_state = epbp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= epbp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // acknowledge needs the settle count plus one edge to reach the filtered level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle <= 2'h0;
      settled_q <= 1'b0;
    end else if (state != epbp_pkg::ST_ACCESS) begin
      settle <= 2'h0;
      settled_q <= 1'b0;
    end else begin
      settled_q <= settled;
      if (!settled) begin
        settle <= settle + 2'h1;
      end
    end
  end

  // address, selects and early store select launch on the same edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_address_o <= 32'h0;
      bank_select_n_o <= epbp_pkg::SELECTS_IDLE;
      early_store_select_n_o <= 1'b1;
      rd_strobe_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      ext_data_bus_o <= 48'h0;
      page_boundary_o <= 1'b0;
      cur_write <= 1'b0;
      cur_cond <= 1'b0;
      cur_format <= 2'h0;
    end else if (req_fire) begin
      ext_address_o <= req_addr_i;
      bank_select_n_o <= req_selects;
      early_store_select_n_o <= ~req_write_i;
      rd_strobe_n_o <= ~(~req_write_i & req_cond_true_i);
      wr_strobe_n_o <= ~(req_write_i & req_cond_true_i);
      ext_data_bus_o <= place(req_format_i, req_wdata_i);
      page_boundary_o <= req_new_page;
      cur_write <= req_write_i;
      cur_cond <= req_cond_true_i;
      cur_format <= req_format_i;
    end else if (access_done) begin
      bank_select_n_o <= epbp_pkg::SELECTS_IDLE;
      early_store_select_n_o <= 1'b1;
      rd_strobe_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      page_boundary_o <= 1'b0;
    end else if (!is_master_i) begin
      ext_data_bus_o <= slv_data_q;
    end
  end

  // last dram page seen in bank 0
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_page <= 32'h0;
      last_page_valid <= 1'b0;
    end else if (req_fire && req_bank0) begin
      last_page <= req_page;
      last_page_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 40'h0;
    end else begin
      rsp_valid_o <= access_done;
      if (access_done && !cur_write && cur_cond) begin
        rsp_rdata_o <= extract(cur_format, ext_data_bus_i);
      end
    end
  end

  // reference clock toggles while running
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_reference_clock_o <= 1'b0;
    end else begin
      bus_reference_clock_o <= ~bus_reference_clock_o;
    end
  end

  // slave side: address from outside, direction from early store select
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slv_rd_prev <= 1'b1;
      slv_wr_prev <= 1'b1;
      slv_valid_o <= 1'b0;
      slv_write_o <= 1'b0;
      slv_addr_o <= 32'h0;
      slv_wdata_o <= 48'h0;
      slv_data_q <= 48'h0;
    end else begin
      slv_rd_prev <= rd_s;
      slv_wr_prev <= wr_s;
      slv_valid_o <= slv_rd_fall | slv_wr_fall;
      slv_data_q <= slv_rdata_i;
      if (slv_rd_fall || slv_wr_fall) begin
        slv_write_o <= ~store_s;
        slv_addr_o <= ext_address_i;
        slv_wdata_o <= ext_data_bus_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_idle_selects;
    (state == epbp_pkg::ST_IDLE) |-> (bank_select_n_o == epbp_pkg::SELECTS_IDLE);
  endproperty
  a_idle_selects: assert property (p_idle_selects) else $error("selects active while idle");

  property p_false_cond;
    (req_fire && !req_cond_true_i && req_bank[2]) |=>
      (bank_select_n_o != epbp_pkg::SELECTS_IDLE) && rd_strobe_n_o && wr_strobe_n_o;
  endproperty
  a_false_cond: assert property (p_false_cond) else $error("false conditional select wrong");

  property p_store_with_addr;
    (req_fire && req_write_i) |=>
      !early_store_select_n_o && (ext_address_o == $past(req_addr_i));
  endproperty
  a_store_with_addr: assert property (p_store_with_addr) else $error("store select late");

  property p_read_strobe;
    (req_fire && !req_write_i && req_cond_true_i) |=> !rd_strobe_n_o && wr_strobe_n_o;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe not low");

  property p_write_strobe;
    (req_fire && req_write_i && req_cond_true_i) |=> !wr_strobe_n_o ##1 !wr_strobe_n_o;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe not low");

  property p_page_bank0;
    page_boundary_o |-> (bank_select_n_o == 4'he);
  endproperty
  a_page_bank0: assert property (p_page_bank0) else $error("page outside bank 0");

  property p_lanes32;
    (req_fire && req_write_i && req_format_i == epbp_pkg::FMT_WORD32) |=>
      (ext_data_bus_o[47:16] == $past(req_wdata_i[31:0])) && (ext_data_bus_o[15:0] == 16'h0);
  endproperty
  a_lanes32: assert property (p_lanes32) else $error("word lanes wrong");

  property p_float;
    (suspend || !is_master_i) |-> !ext_address_oe_o && !bank_select_oe_o && !rd_strobe_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while floated");

  property p_ack_wait;
    (state == epbp_pkg::ST_ACCESS && cur_cond && !ack_s && !suspend) |=>
      (state == epbp_pkg::ST_ACCESS);
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("access ended during wait");

  property p_slave_dir;
    (slv_rd_fall || slv_wr_fall) |=> slv_valid_o && (slv_write_o == !$past(store_s));
  endproperty
  a_slave_dir: assert property (p_slave_dir) else $error("slave direction wrong");

  property p_ext_lanes;
    (req_fire && req_write_i && req_format_i == epbp_pkg::FMT_EXT40) |=>
      (ext_data_bus_o[47:8] == $past(req_wdata_i)) && (ext_data_bus_o[7:0] == 8'h0);
  endproperty
  a_ext_lanes: assert property (p_ext_lanes) else $error("extended lanes wrong");

  property p_short_lanes;
    (req_fire && req_write_i && req_format_i == epbp_pkg::FMT_SHORT16) |=>
      (ext_data_bus_o == {16'h0, $past(req_wdata_i[15:0]), 16'h0});
  endproperty
  a_short_lanes: assert property (p_short_lanes) else $error("short word lanes wrong");

  property p_boot_read;
    (access_done && !cur_write && cur_cond && cur_format == epbp_pkg::FMT_BOOT8) |=>
      (rsp_rdata_o == {32'h0, $past(ext_data_bus_i[23:16])});
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot byte lanes wrong");

  property p_suspend_hold;
    (state == epbp_pkg::ST_ACCESS && suspend) |=> (state == epbp_pkg::ST_ACCESS);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("moved in suspend");

  property p_sel_with_addr;
    req_fire |=>
      (ext_address_o == $past(req_addr_i)) && (bank_select_n_o == $past(req_selects));
  endproperty
  a_sel_with_addr: assert property (p_sel_with_addr) else $error("selects not with address");

  c_read: cover property (req_fire && !req_write_i ##[1:20] rsp_valid_o);
  c_page: cover property (page_boundary_o);
  c_suspend: cover property (state == epbp_pkg::ST_ACCESS && suspend);
  c_wait: cover property (state == epbp_pkg::ST_ACCESS && cur_cond && !ack_s);
  c_slave_write: cover property (slv_valid_o && slv_write_o);
endmodule // epbp_port

// ### rtl/epbp_sync.sv
/*
  three-stage synchroniser with agreement filter for the port's pin inputs.
  assumes inputs idle high after reset.
*/
`timescale 1ns/1ns
module epbp_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] async_i,
  output logic [4:0] stable_o
);
  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] stage3;
  wire [4:0] agree = ~(stage2 ^ stage3);
  wire [4:0] next_stable = (agree & stage3) | (~agree & stable_o);

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= epbp_pkg::SYNC_RESET;
      stage2 <= epbp_pkg::SYNC_RESET;
      stage3 <= epbp_pkg::SYNC_RESET;
      stable_o <= epbp_pkg::SYNC_RESET;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      stable_o <= next_stable;
    end
  end
endmodule // epbp_sync
